// ===== hw/cpu_memory_space_decoder.sv
// CPU memory space decoder: code, internal data, SFR map, pointers and direct ports
// Behaviour
// - Code space 64 KB, main flash only
// - 256 RAM bytes plus 128 overlapping SFRs
// - Lowest 32 bytes: four banks R0-R7
// - Next 16 bytes are bit-addressable
// - Lower 128 bytes direct and indirect reachable
// - Direct upper-half access goes to SFRs
// - Indirect upper-half access goes to RAM
// - Stack uses indirect addressing, full 256 bytes
// - Select register picks active data pointer
// - Extension registers used only for external moves
// - Pointer move top byte from paired extension
// - Ri move uses top and middle extensions
// - 24-bit external addresses, 8/16-bit data path
// - Direct port SFRs at listed map positions
// - Source select bit picks direct or hub data
// - Pin state register read-only, shows pins
`timescale 1ns/10ps

module cpu_memory_space_decoder
    import memdec_pkg::*;
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Code fetch
    input wire logic code_req_i,
    input wire logic [CODE_AW-1:0] code_addr_i,
    output logic code_flash_sel_o,
    output logic [CODE_AW-1:0] code_flash_addr_o,
    // Internal data access
    input wire idata_req_t idata_req_i,
    output logic idata_ack_o,
    output logic [7:0] idata_rdata_o,
    // Data pointer operations
    input wire ptr_op_t ptr_op_i,
    input wire logic [15:0] ptr_load_i,
    output logic [15:0] active_ptr_o,
    // External data moves
    input wire xdata_req_t xdata_req_i,
    input wire logic ext_bus_wide_i,
    output xdata_bus_t xdata_bus_o,
    // Ports
    input wire logic [PORT_COUNT-1:0][7:0] hub_port_out_data_i,
    input wire logic [PORT_COUNT-1:0][7:0] pin_state_i,
    output logic [PORT_COUNT-1:0][7:0] pin_out_o
);

    logic [IDATA_SIZE-1:0][7:0] ram_q;
    logic [7:0] stack_pointer_q;
    logic [1:0][7:0] ptr_low_q;
    logic [1:0][7:0] ptr_high_q;
    logic [1:0][7:0] ptr_ext_high_q;
    logic [7:0] data_pointer_select_q;
    logic [7:0] indirect_top_ext_q;
    logic [7:0] indirect_mid_ext_q;
    logic [7:0] int_enable_mask_q;
    logic [7:0] program_status_word_q;
    logic [7:0] work_operand_a_q;
    logic [7:0] mul_div_operand_q;
    logic [PORT_COUNT-1:0][7:0] direct_port_out_data_q;
    logic [PORT_COUNT-1:0][7:0] direct_port_out_source_q;

    logic tgt_sfr;
    logic [7:0] tgt_addr;
    logic is_bit;
    logic [2:0] bit_pos;
    logic [7:0] sfr_rd;
    logic [7:0] byte_rd;
    logic [7:0] wr_val;
    logic wr_en;
    logic ram_we;
    logic sfr_we;
    logic ptr_idx;

    // Port table lookup: {hit, index}
    function automatic logic [4:0] port_lookup(input logic [7:0] a,
                                               input logic [PORT_COUNT-1:0][7:0] tbl);
        logic [4:0] r;
        r = 5'h0;
        for (int i = 0; i < PORT_COUNT; i++) begin
            if (a == tbl[i]) begin
                r = {1'b1, 4'(i)};
            end
        end
        return r;
    endfunction

    function automatic logic [7:0] set_bit(input logic [7:0] b, input logic [2:0] pos,
                                           input logic v);
        logic [7:0] r;
        r = b;
        r[pos] = v;
        return r;
    endfunction

    function automatic logic [7:0] port_mux(input logic [7:0] sel, input logic [7:0] dr,
                                            input logic [7:0] hub);
        return (sel & dr) | (~sel & hub);
    endfunction

    assign ptr_idx = data_pointer_select_q[0];

    // Target selection per addressing mode
    always_comb begin
        tgt_sfr = 1'b0;
        tgt_addr = idata_req_i.addr;
        is_bit = 1'b0;
        bit_pos = idata_req_i.addr[2:0];
        case (idata_req_i.mode)
            ACC_DIRECT: begin
                tgt_sfr = idata_req_i.addr[7];
            end
            ACC_INDIRECT: begin
                tgt_sfr = 1'b0;
            end
            ACC_REG: begin
                tgt_addr = {PSW_BANK_HI, 1'b0,
                            program_status_word_q[PSW_BANK_LSB+1:PSW_BANK_LSB],
                            idata_req_i.addr[2:0]};
            end
            ACC_BIT: begin
                is_bit = 1'b1;
                if (idata_req_i.addr[7]) begin
                    tgt_sfr = 1'b1;
                    tgt_addr = {idata_req_i.addr[7:3], 3'h0};
                end else begin
                    tgt_addr = BIT_AREA_BASE | {4'h0, idata_req_i.addr[6:3]};
                end
            end
            ACC_PUSH: begin
                tgt_addr = stack_pointer_q + ONE_BYTE;
            end
            ACC_POP: begin
                tgt_addr = stack_pointer_q;
            end
            default: begin
                tgt_addr = idata_req_i.addr;
            end
        endcase
    end

    // SFR read decode
    always_comb begin
        logic [4:0] hdr;
        logic [4:0] hps;
        logic [4:0] hsel;
        hdr = port_lookup(tgt_addr, PORT_DR_ADDR);
        hps = port_lookup(tgt_addr, PORT_PS_ADDR);
        hsel = port_lookup(tgt_addr, PORT_SEL_ADDR);
        case (tgt_addr)
            SFR_SP: sfr_rd = stack_pointer_q;
            SFR_PTR0_LOW: sfr_rd = ptr_low_q[0];
            SFR_PTR0_HIGH: sfr_rd = ptr_high_q[0];
            SFR_PTR1_LOW: sfr_rd = ptr_low_q[1];
            SFR_PTR1_HIGH: sfr_rd = ptr_high_q[1];
            SFR_DPS: sfr_rd = data_pointer_select_q;
            SFR_PTR0_EXT: sfr_rd = ptr_ext_high_q[0];
            SFR_PTR1_EXT: sfr_rd = ptr_ext_high_q[1];
            SFR_IND_MID: sfr_rd = indirect_mid_ext_q;
            SFR_IE: sfr_rd = int_enable_mask_q;
            SFR_PSW: sfr_rd = program_status_word_q;
            SFR_ACC: sfr_rd = work_operand_a_q;
            SFR_IND_TOP: sfr_rd = indirect_top_ext_q;
            SFR_B: sfr_rd = mul_div_operand_q;
            default: begin
                if (hdr[4]) begin
                    sfr_rd = direct_port_out_data_q[hdr[3:0]];
                end else if (hps[4]) begin
                    sfr_rd = pin_state_i[hps[3:0]];
                end else if (hsel[4]) begin
                    sfr_rd = direct_port_out_source_q[hsel[3:0]];
                end else begin
                    sfr_rd = ZERO_BYTE;
                end
            end
        endcase
    end

    // Bit writes are read-modify-write of the whole byte in one cycle
    assign byte_rd = tgt_sfr ? sfr_rd : ram_q[tgt_addr];
    assign wr_val = is_bit ? set_bit(byte_rd, bit_pos, idata_req_i.wdata[0])
                           : idata_req_i.wdata;
    assign wr_en = idata_req_i.valid &&
                   (idata_req_i.mode == ACC_PUSH ||
                    (idata_req_i.we && idata_req_i.mode != ACC_POP));
    assign ram_we = wr_en && !tgt_sfr;
    assign sfr_we = wr_en && tgt_sfr;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ram_q <= '0;
        end else if (ram_we) begin
            ram_q[tgt_addr] <= wr_val;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stack_pointer_q <= SP_RST;
        end else if (idata_req_i.valid && idata_req_i.mode == ACC_PUSH) begin
            stack_pointer_q <= stack_pointer_q + ONE_BYTE;
        end else if (idata_req_i.valid && idata_req_i.mode == ACC_POP) begin
            stack_pointer_q <= stack_pointer_q - ONE_BYTE;
        end else if (sfr_we && tgt_addr == SFR_SP) begin
            stack_pointer_q <= wr_val;
        end
    end

    // Pointer operations win over a same-cycle SFR write to the active pointer
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ptr_low_q <= '0;
            ptr_high_q <= '0;
        end else begin
            if (sfr_we) begin
                case (tgt_addr)
                    SFR_PTR0_LOW: ptr_low_q[0] <= wr_val;
                    SFR_PTR0_HIGH: ptr_high_q[0] <= wr_val;
                    SFR_PTR1_LOW: ptr_low_q[1] <= wr_val;
                    SFR_PTR1_HIGH: ptr_high_q[1] <= wr_val;
                    default: begin
                    end
                endcase
            end
            case (ptr_op_i)
                PTR_INC: begin
                    {ptr_high_q[ptr_idx], ptr_low_q[ptr_idx]} <=
                        {ptr_high_q[ptr_idx], ptr_low_q[ptr_idx]} + 16'h0001;
                end
                PTR_LOAD: begin
                    {ptr_high_q[ptr_idx], ptr_low_q[ptr_idx]} <= ptr_load_i;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_pointer_select_q <= SFR_RST;
            ptr_ext_high_q <= '0;
            indirect_top_ext_q <= SFR_RST;
            indirect_mid_ext_q <= SFR_RST;
            int_enable_mask_q <= SFR_RST;
            program_status_word_q <= SFR_RST;
            work_operand_a_q <= SFR_RST;
            mul_div_operand_q <= SFR_RST;
        end else if (sfr_we) begin
            case (tgt_addr)
                SFR_DPS: data_pointer_select_q <= wr_val;
                SFR_PTR0_EXT: ptr_ext_high_q[0] <= wr_val;
                SFR_PTR1_EXT: ptr_ext_high_q[1] <= wr_val;
                SFR_IND_TOP: indirect_top_ext_q <= wr_val;
                SFR_IND_MID: indirect_mid_ext_q <= wr_val;
                SFR_IE: int_enable_mask_q <= wr_val;
                SFR_PSW: program_status_word_q <= wr_val;
                SFR_ACC: work_operand_a_q <= wr_val;
                SFR_B: mul_div_operand_q <= wr_val;
                default: begin
                end
            endcase
        end
    end

    // Pin state addresses are absent here, so writes to them fall away
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            direct_port_out_data_q <= '0;
            direct_port_out_source_q <= '0;
        end else if (sfr_we) begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                if (tgt_addr == PORT_DR_ADDR[i]) begin
                    direct_port_out_data_q[i] <= wr_val;
                end
                if (tgt_addr == PORT_SEL_ADDR[i]) begin
                    direct_port_out_source_q[i] <= wr_val;
                end
            end
        end
    end

    // Pin drive, one cycle behind the select and data registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_out_o <= '0;
        end else begin
            for (int i = 0; i < PORT_COUNT; i++) begin
                pin_out_o[i] <= port_mux(direct_port_out_source_q[i],
                                         direct_port_out_data_q[i],
                                         hub_port_out_data_i[i]);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            idata_ack_o <= 1'b0;
            idata_rdata_o <= ZERO_BYTE;
        end else begin
            idata_ack_o <= idata_req_i.valid;
            if (idata_req_i.valid) begin
                idata_rdata_o <= is_bit ? {7'h0, byte_rd[bit_pos]} : byte_rd;
            end
        end
    end

    // Every code address lands in main flash
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            code_flash_sel_o <= 1'b0;
            code_flash_addr_o <= '0;
        end else begin
            code_flash_sel_o <= code_req_i;
            if (code_req_i) begin
                code_flash_addr_o <= code_addr_i;
            end
        end
    end

    // Selected pointer for table reads and indirect jumps, one cycle late
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_ptr_o <= '0;
        end else begin
            active_ptr_o <= {ptr_high_q[ptr_idx], ptr_low_q[ptr_idx]};
        end
    end

    // Extension bytes reach only the external move path
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xdata_bus_o <= '0;
        end else begin
            xdata_bus_o.valid <= xdata_req_i.valid;
            xdata_bus_o.we <= xdata_req_i.valid && xdata_req_i.we;
            xdata_bus_o.wide <= ext_bus_wide_i;
            if (xdata_req_i.valid) begin
                xdata_bus_o.wdata <= xdata_req_i.wdata;
                if (xdata_req_i.via_ri) begin
                    xdata_bus_o.addr <= {indirect_top_ext_q, indirect_mid_ext_q,
                                         ram_q[{PSW_BANK_HI, 1'b0,
                                         program_status_word_q[PSW_BANK_LSB+1:PSW_BANK_LSB],
                                         2'h0, xdata_req_i.ri_sel}]};
                end else begin
                    xdata_bus_o.addr <= {ptr_ext_high_q[ptr_idx], ptr_high_q[ptr_idx],
                                         ptr_low_q[ptr_idx]};
                end
            end
        end
    end

    // Checks
    logic [7:0] ext_sel_val;
    logic [7:0] ram_at_tgt;
    logic [7:0] port0_mux;
    assign ext_sel_val = ptr_ext_high_q[ptr_idx];
    assign ram_at_tgt = ram_q[tgt_addr];
    assign port0_mux = port_mux(direct_port_out_source_q[0], direct_port_out_data_q[0],
                                hub_port_out_data_i[0]);

    sequence s_ptr_move;
        xdata_req_i.valid && !xdata_req_i.via_ri;
    endsequence

    sequence s_ri_move;
        xdata_req_i.valid && xdata_req_i.via_ri;
    endsequence

    sequence s_ram_read;
        idata_req_i.valid && !tgt_sfr && !is_bit;
    endsequence

    property p_code_flash;
        @(posedge clock_i) disable iff (!rst_n_i)
        code_req_i |=> code_flash_sel_o && code_flash_addr_o == $past(code_addr_i);
    endproperty
    a_code_flash: assert property (p_code_flash) else $error("code fetch not mapped");

    property p_upper_direct;
        @(posedge clock_i) disable iff (!rst_n_i)
        (idata_req_i.valid && idata_req_i.mode == ACC_DIRECT && !idata_req_i.we &&
         idata_req_i.addr == SFR_ACC) |=> idata_rdata_o == $past(work_operand_a_q);
    endproperty
    a_upper_direct: assert property (p_upper_direct) else $error("direct not SFR");

    property p_ram_read;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_ram_read |=> idata_ack_o && idata_rdata_o == $past(ram_at_tgt);
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("RAM read mismatch");

    property p_push;
        @(posedge clock_i) disable iff (!rst_n_i)
        (idata_req_i.valid && idata_req_i.mode == ACC_PUSH) |=>
            stack_pointer_q == $past(stack_pointer_q) + ONE_BYTE &&
            ram_q[stack_pointer_q] == $past(idata_req_i.wdata);
    endproperty
    a_push: assert property (p_push) else $error("push wrong");

    property p_ptr_move;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_ptr_move |=> xdata_bus_o.valid && xdata_bus_o.addr[23:16] == $past(ext_sel_val);
    endproperty
    a_ptr_move: assert property (p_ptr_move) else $error("pointer ext byte wrong");

    property p_ri_move;
        @(posedge clock_i) disable iff (!rst_n_i)
        s_ri_move |=> xdata_bus_o.addr[23:8] ==
            {$past(indirect_top_ext_q), $past(indirect_mid_ext_q)};
    endproperty
    a_ri_move: assert property (p_ri_move) else $error("Ri ext bytes wrong");

    property p_pin_out;
        @(posedge clock_i) disable iff (!rst_n_i)
        1'b1 |=> pin_out_o[0] == $past(port0_mux);
    endproperty
    a_pin_out: assert property (p_pin_out) else $error("pin source wrong");

    property p_pin_state;
        @(posedge clock_i) disable iff (!rst_n_i)
        (idata_req_i.valid && idata_req_i.mode == ACC_DIRECT &&
         idata_req_i.addr == PORT_PS_ADDR[0]) |=> idata_rdata_o == $past(pin_state_i[0]);
    endproperty
    a_pin_state: assert property (p_pin_state) else $error("pin state wrong");

    property p_unmapped;
        @(posedge clock_i) disable iff (!rst_n_i)
        (idata_req_i.valid && idata_req_i.mode == ACC_DIRECT &&
         idata_req_i.addr == 8'hfb) |=> idata_rdata_o == ZERO_BYTE;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not zero");

endmodule

// ===== hw/memdec_pkg.sv
// Constants, types and the special function register map for the memory space decoder
package memdec_pkg;

    // Address widths and sizes of the three CPU spaces, and the port count
    localparam int CODE_AW = 16;
    localparam int XDATA_AW = 24;
    localparam int IDATA_SIZE = 256;
    localparam int PORT_COUNT = 9;

    // Internal data layout
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [1:0] PSW_BANK_HI = 2'h0;
    localparam int PSW_BANK_LSB = 3;

    // Standard special function registers
    localparam logic [7:0] SFR_SP = 8'h81;
    localparam logic [7:0] SFR_PTR0_LOW = 8'h82;
    localparam logic [7:0] SFR_PTR0_HIGH = 8'h83;
    localparam logic [7:0] SFR_PTR1_LOW = 8'h84;
    localparam logic [7:0] SFR_PTR1_HIGH = 8'h85;
    localparam logic [7:0] SFR_DPS = 8'h86;
    localparam logic [7:0] SFR_PTR0_EXT = 8'h93;
    localparam logic [7:0] SFR_PTR1_EXT = 8'h95;
    localparam logic [7:0] SFR_IND_MID = 8'ha0;
    localparam logic [7:0] SFR_IE = 8'ha8;
    localparam logic [7:0] SFR_PSW = 8'hd0;
    localparam logic [7:0] SFR_ACC = 8'he0;
    localparam logic [7:0] SFR_IND_TOP = 8'hea;
    localparam logic [7:0] SFR_B = 8'hf0;

    // Direct port registers; index 0..8 stands for ports 0..6, 12, 15
    localparam logic [8:0][7:0] PORT_DR_ADDR =
        {8'hf8, 8'he8, 8'hd8, 8'hc8, 8'hc0, 8'hb0, 8'h98, 8'h90, 8'h80};
    localparam logic [8:0][7:0] PORT_PS_ADDR =
        {8'hf9, 8'he9, 8'hd9, 8'hc9, 8'hc1, 8'hb1, 8'h99, 8'h91, 8'h89};
    localparam logic [8:0][7:0] PORT_SEL_ADDR =
        {8'hfa, 8'hf2, 8'hda, 8'hca, 8'hc2, 8'hb2, 8'h9a, 8'ha2, 8'h8a};

    // Reset values
    localparam logic [7:0] SFR_RST = 8'h00;
    localparam logic [7:0] SP_RST = 8'h00;

    typedef enum logic [2:0] {
        ACC_DIRECT,
        ACC_INDIRECT,
        ACC_REG,
        ACC_BIT,
        ACC_PUSH,
        ACC_POP
    } acc_mode_t;

    typedef enum logic [1:0] {
        PTR_NONE,
        PTR_INC,
        PTR_LOAD
    } ptr_op_t;

    typedef struct packed {
        logic valid;
        acc_mode_t mode;
        logic [7:0] addr;
        logic we;
        logic [7:0] wdata;
    } idata_req_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic via_ri;
        logic ri_sel;
        logic [7:0] wdata;
    } xdata_req_t;

    typedef struct packed {
        logic valid;
        logic we;
        logic [XDATA_AW-1:0] addr;
        logic [7:0] wdata;
        logic wide;
    } xdata_bus_t;

endpackage

// ===== tb/cpu_core_model.sv
// CPU core model issuing code, internal data, pointer and external data requests
`timescale 1ns/10ps
module cpu_core_model
    import memdec_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Internal data answer
    input wire logic idata_ack_i,
    input wire logic [7:0] idata_rdata_i,
    // Requests
    output idata_req_t idata_req_o,
    output xdata_req_t xdata_req_o,
    output ptr_op_t ptr_op_o,
    output logic [15:0] ptr_load_o,
    output logic code_req_o,
    output logic [CODE_AW-1:0] code_addr_o
);
    initial begin
        idata_req_o = '0;
        xdata_req_o = '0;
        ptr_op_o = PTR_NONE;
        ptr_load_o = 16'h0000;
        code_req_o = 1'b0;
        code_addr_o = '0;
    end

    // Stack traffic goes out as push/pop modes, never as direct accesses
    task automatic idata(input acc_mode_t m, input logic [7:0] a, input logic w,
        input logic [7:0] d, output logic [7:0] rd, output logic ak);
        @(negedge clock_i);
        idata_req_o = '{1'b1, m, a, w, d};
        @(negedge clock_i);
        ak = idata_ack_i;
        rd = idata_rdata_i;
        // Released lines carry junk so a stale value cannot pass
        idata_req_o = '{1'b0, ACC_DIRECT, ~a, ~w, ~d};
    endtask

    task automatic xdata(input logic w, input logic ri, input logic rs, input logic [7:0] d);
        @(negedge clock_i);
        xdata_req_o = '{1'b1, w, ri, rs, d};
        @(negedge clock_i);
        xdata_req_o = '{1'b0, ~w, ~ri, ~rs, ~d};
    endtask

    task automatic ptr(input ptr_op_t op, input logic [15:0] v);
        @(negedge clock_i);
        ptr_op_o = op;
        ptr_load_o = v;
        @(negedge clock_i);
        ptr_op_o = PTR_NONE;
        ptr_load_o = ~v;
    endtask

    task automatic code(input logic [CODE_AW-1:0] a);
        @(negedge clock_i);
        code_req_o = 1'b1;
        code_addr_o = a;
        @(negedge clock_i);
        code_req_o = 1'b0;
        code_addr_o = ~a;
    endtask
endmodule

// ===== tb/cpu_memory_space_decoder_bench.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/10ps
module cpu_memory_space_decoder_bench
    import memdec_pkg::*;
;
    typedef struct packed {
        acc_mode_t m;
        logic [7:0] a;
        logic w;
        logic [7:0] d;
        logic [7:0] e;
    } row_t;
    // Writes answer with the old byte, bit writes with the old bit
    row_t rows [0:31] = '{
        '{ACC_DIRECT, 8'h10, 1, 8'ha5, 8'h00}, '{ACC_INDIRECT, 8'h10, 0, 8'h00, 8'ha5},
        '{ACC_INDIRECT, 8'h90, 1, 8'h3c, 8'h00}, '{ACC_DIRECT, 8'h90, 0, 8'h00, 8'h00},
        '{ACC_DIRECT, 8'h90, 1, 8'h5a, 8'h00}, '{ACC_INDIRECT, 8'h90, 0, 8'h00, 8'h3c},
        '{ACC_DIRECT, 8'h90, 0, 8'h00, 8'h5a}, '{ACC_DIRECT, 8'h03, 1, 8'h11, 8'h00},
        '{ACC_REG, 8'h03, 0, 8'h00, 8'h11}, '{ACC_DIRECT, 8'hd0, 1, 8'h08, 8'h00},
        '{ACC_REG, 8'h03, 1, 8'h22, 8'h00}, '{ACC_INDIRECT, 8'h0b, 0, 8'h00, 8'h22},
        '{ACC_DIRECT, 8'h21, 1, 8'h00, 8'h00}, '{ACC_BIT, 8'h0d, 1, 8'h01, 8'h00},
        '{ACC_DIRECT, 8'h21, 0, 8'h00, 8'h20}, '{ACC_BIT, 8'h0d, 0, 8'h00, 8'h01},
        '{ACC_DIRECT, 8'hb8, 1, 8'hff, 8'h00}, '{ACC_DIRECT, 8'hb8, 0, 8'h00, 8'h00},
        '{ACC_DIRECT, 8'h91, 1, 8'hff, 8'h41}, '{ACC_DIRECT, 8'h91, 0, 8'h00, 8'h41},
        '{ACC_DIRECT, 8'hf8, 1, 8'h5a, 8'h00}, '{ACC_DIRECT, 8'hf8, 0, 8'h00, 8'h5a},
        '{ACC_DIRECT, 8'he0, 1, 8'h3c, 8'h00}, '{ACC_DIRECT, 8'he0, 0, 8'h00, 8'h3c},
        '{ACC_DIRECT, 8'hfb, 1, 8'hff, 8'h00}, '{ACC_DIRECT, 8'hfb, 0, 8'h00, 8'h00},
        '{ACC_DIRECT, 8'h81, 1, 8'hf0, 8'h00}, '{ACC_PUSH, 8'h00, 1, 8'h77, 8'h00},
        '{ACC_INDIRECT, 8'hf1, 0, 8'h00, 8'h77}, '{ACC_DIRECT, 8'h81, 0, 8'h00, 8'hf1},
        '{ACC_POP, 8'h00, 0, 8'h00, 8'h77}, '{ACC_DIRECT, 8'h81, 0, 8'h00, 8'hf0}};
    // Ports 0..6, 12 and 15 in index order
    logic [7:0] dr_a [0:8] = '{8'h80, 8'h90, 8'h98, 8'hb0, 8'hc0, 8'hc8, 8'hd8, 8'he8, 8'hf8};
    logic [7:0] ps_a [0:8] = '{8'h89, 8'h91, 8'h99, 8'hb1, 8'hc1, 8'hc9, 8'hd9, 8'he9, 8'hf9};
    logic [7:0] sel_a [0:8] = '{8'h8a, 8'ha2, 8'h9a, 8'hb2, 8'hc2, 8'hca, 8'hda, 8'hf2, 8'hfa};
    logic [7:0] pa [0:8] = '{8'h93, 8'h83, 8'h82, 8'h95, 8'h85, 8'h84, 8'ha0, 8'hea, 8'h09};
    logic [7:0] pd [0:8] = '{8'h12, 8'h34, 8'h56, 8'hab, 8'hcd, 8'hef, 8'h9a, 8'hbc, 8'h5e};
    logic clock_i, rst_n_i, code_req, code_sel, ack, wide, ak;
    logic [15:0] code_addr, code_out, ptr_load, act_ptr;
    idata_req_t idata_req;
    xdata_req_t xdata_req;
    xdata_bus_t xb;
    ptr_op_t ptr_op;
    logic [7:0] rdata, rd;
    logic [PORT_COUNT-1:0][7:0] hub, pins, pout;
    int n_fail = 0, checks = 0, cycles = 0;

    cpu_memory_space_decoder cpu_memory_space_decoder_inst (.clock_i(clock_i),
        .rst_n_i(rst_n_i), .code_req_i(code_req), .code_addr_i(code_addr),
        .code_flash_sel_o(code_sel), .code_flash_addr_o(code_out), .idata_req_i(idata_req),
        .idata_ack_o(ack), .idata_rdata_o(rdata), .ptr_op_i(ptr_op), .ptr_load_i(ptr_load),
        .active_ptr_o(act_ptr), .xdata_req_i(xdata_req), .ext_bus_wide_i(wide),
        .xdata_bus_o(xb), .hub_port_out_data_i(hub), .pin_state_i(pins), .pin_out_o(pout));
    cpu_core_model cpu_core_model_inst (.clock_i(clock_i), .idata_ack_i(ack),
        .idata_rdata_i(rdata), .idata_req_o(idata_req), .xdata_req_o(xdata_req),
        .ptr_op_o(ptr_op), .ptr_load_o(ptr_load), .code_req_o(code_req),
        .code_addr_o(code_addr));

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    // Whole run is under 200 cycles
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 4000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic chk24(input string n, input logic [23:0] e, input logic [23:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        cpu_core_model_inst.idata(ACC_DIRECT, a, 1'b1, d, rd, ak);
    endtask
    task automatic stop_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        rst_n_i = 1'b0;
        wide = 1'b1;
        hub = {PORT_COUNT{8'h33}};
        for (int i = 0; i < PORT_COUNT; i++)
            pins[i] = 8'h40 + i;
        repeat (12) @(negedge clock_i);
        chk24("reset bus", 24'h0, xb.addr);
        rst_n_i = 1'b1;
        foreach (rows[i]) begin
            cpu_core_model_inst.idata(rows[i].m, rows[i].a, rows[i].w, rows[i].d, rd, ak);
            chk8("ack", 8'h01, {7'h0, ak});
            chk8("idata", rows[i].e, rd);
        end
        $display("test rows done");
        for (int i = 0; i < PORT_COUNT; i++) begin
            chk8("hub pin", 8'h33, pout[i]);
            wr(dr_a[i], 8'ha5);
            wr(sel_a[i], 8'h0f);
            @(negedge clock_i);
            chk8("mixed pin", 8'h35, pout[i]);
            cpu_core_model_inst.idata(ACC_DIRECT, ps_a[i], 1'b0, 8'h00, rd, ak);
            chk8("pin state", 8'h40 + i, rd);
        end
        $display("test ports done");
        foreach (pa[i])
            wr(pa[i], pd[i]);
        cpu_core_model_inst.xdata(1'b0, 1'b0, 1'b0, 8'h00);
        chk24("ptr0 move", 24'h123456, xb.addr);
        chk8("wide", 8'h03, {6'h0, xb.wide, xb.valid});
        wr(8'h86, 8'h01);
        cpu_core_model_inst.xdata(1'b1, 1'b0, 1'b0, 8'h66);
        chk24("ptr1 move", 24'habcdef, xb.addr);
        chk8("wdata", 8'h66, xb.wdata);
        wide = 1'b0;
        cpu_core_model_inst.xdata(1'b0, 1'b1, 1'b1, 8'h00);
        chk24("ri move", 24'hbc9a5e, xb.addr);
        chk8("narrow", 8'h01, {6'h0, xb.wide, xb.valid});
        cpu_core_model_inst.ptr(PTR_LOAD, 16'h1000);
        cpu_core_model_inst.ptr(PTR_INC, 16'h0000);
        @(negedge clock_i);
        chk24("active ptr", 24'h001001, {8'h0, act_ptr});
        cpu_core_model_inst.xdata(1'b0, 1'b0, 1'b0, 8'h00);
        chk24("inc move", 24'hab1001, xb.addr);
        cpu_core_model_inst.code(16'hbeef);
        chk24("code fetch", 24'h01beef, {7'h0, code_sel, code_out});
        @(negedge clock_i);
        chk8("code sel", 8'h00, {7'h0, code_sel});
        $display("test pointers done");
        rst_n_i = 1'b0;
        @(negedge clock_i);
        rst_n_i = 1'b1;
        chk8("pin reset", 8'h00, pout[1]);
        cpu_core_model_inst.idata(ACC_DIRECT, 8'h81, 1'b0, 8'h00, rd, ak);
        chk8("sp reset", SP_RST, rd);
        cpu_core_model_inst.idata(ACC_INDIRECT, 8'h10, 1'b0, 8'h00, rd, ak);
        chk8("ram reset", 8'h00, rd);
        $display("test reset done");
        stop_test();
    end
endmodule
